// ### vectored_interrupt_control.v
// Purpose: fixed-priority vectored interrupt controller
// Assumes: core pulses accept_point once per instruction boundary
// Notes: request flags set wins over software clear
`timescale 1ns/1ps
`include "vic_defines.vh"
module vectored_interrupt_control #(
   parameter KEYW = 8
) (
   input  wire            clk,
   input  wire            rst_n,
   input  wire            ce,
   input  wire [KEYW-1:0] key_port,
   input  wire [KEYW-1:0] key_port_dir,
   input  wire [KEYW-1:0] key_select,
   input  wire            ext_irq_a,
   input  wire            ext_irq_b,
   input  wire            ext_a_rising,
   input  wire            ext_b_rising,
   input  wire            timer1_underflow,
   input  wire            timer2_underflow,
   input  wire            timer3_underflow,
   input  wire            software_break_instr,
   input  wire            accept_point,
   input  wire [7:0]      status_in,
   input  wire [5:0]      enable_bits,
   input  wire [5:0]      req_clear,
   output reg  [5:0]      request_bits,
   output reg             irq_taken,
   output reg  [15:0]     vector_low_addr,
   output reg  [15:0]     vector_high_addr,
   output reg             set_disable_flag,
   output reg             stop_release
);
   wire [KEYW-1:0] key_sync;
   wire            exta_sync;
   wire            extb_sync;
   reg             key_and_q;
   reg             exta_q;
   reg             extb_q;
   reg  [2:0]      prime_count;
   wire            sync_primed;
   wire            take_hw;
   reg             in_reset_vec;
   wire            key_and;
   wire [5:0]      events;
   wire [5:0]      eligible;
   wire [5:0]      grant;
   wire            grant_any;
   wire            iflag;
   reg  [15:0]     next_vec;

   vic_sync #(.W(KEYW)) u_key_sync (
      .clk   (clk),
      .rst_n (rst_n),
      .ce    (ce),
      .din   (key_port),
      .dout  (key_sync)
   );
   vic_sync #(.W(2)) u_ext_sync (
      .clk   (clk),
      .rst_n (rst_n),
      .ce    (ce),
      .din   ({ext_irq_b, ext_irq_a}),
      .dout  ({extb_sync, exta_sync})
   );

   // Pin history is only trusted once the synchroniser has filled
   assign sync_primed = (prime_count == `VIC_PRIME_CYCLES);
   // Unselected or output pins read as 1 so they never mask keys
   assign key_and = &(key_sync | ~key_select | key_port_dir);
   assign events[`VIC_SRC_KEY]  = sync_primed && (key_and != key_and_q);
   assign events[`VIC_SRC_EXTA] = sync_primed && (ext_a_rising ? (exta_sync & ~exta_q)
                                                                : (~exta_sync & exta_q));
   assign events[`VIC_SRC_EXTB] = sync_primed && (ext_b_rising ? (extb_sync & ~extb_q)
                                                                : (~extb_sync & extb_q));
   assign events[`VIC_SRC_T2]   = timer2_underflow;
   assign events[`VIC_SRC_T3]   = timer3_underflow;
   assign events[`VIC_SRC_T1]   = timer1_underflow;

   assign iflag    = status_in[`VIC_IFLAG_BIT];
   assign eligible = (iflag ? `VIC_ZERO6 : (request_bits & enable_bits));

   vic_prio #(.N(`VIC_NSRC)) u_prio (
      .req   (eligible),
      .grant (grant),
      .any   (grant_any)
   );

   // Consumed boundary after reset must not clear pending requests
   assign take_hw = accept_point && !in_reset_vec && grant_any;

   always @* begin
      next_vec = `VIC_VEC_BRK;
      case (grant)
         `VIC_GNT_KEY:  next_vec = `VIC_VEC_KEY;
         `VIC_GNT_EXTA: next_vec = `VIC_VEC_EXTA;
         `VIC_GNT_EXTB: next_vec = `VIC_VEC_EXTB;
         `VIC_GNT_T2:   next_vec = `VIC_VEC_T2;
         `VIC_GNT_T3:   next_vec = `VIC_VEC_T3;
         `VIC_GNT_T1:   next_vec = `VIC_VEC_T1;
         default: next_vec = `VIC_VEC_BRK;
      endcase
   end

   always @(posedge clk) begin
      if (!rst_n) begin
         request_bits     <= `VIC_ZERO6;
         key_and_q        <= 1'b1;
         exta_q           <= 1'b0;
         extb_q           <= 1'b0;
         prime_count      <= `VIC_ZERO3;
         in_reset_vec     <= 1'b1;
         irq_taken        <= 1'b0;
         vector_low_addr  <= `VIC_VEC_RESET;
         vector_high_addr <= `VIC_VEC_RESET + `VIC_VEC_STEP;
         set_disable_flag <= 1'b1;
         stop_release     <= 1'b0;
      end else if (ce) begin
         key_and_q    <= key_and;
         exta_q       <= exta_sync;
         extb_q       <= extb_sync;
         // Reset values of the sync stages would look like pin edges
         if (!sync_primed) begin
            prime_count <= prime_count + `VIC_PRIME_ONE;
         end
         stop_release <= timer1_underflow;
         irq_taken    <= 1'b0;
         set_disable_flag <= 1'b0;
         // Event set wins over software clear and over acceptance
         request_bits <= (request_bits & ~req_clear & ~(take_hw ? grant : `VIC_ZERO6))
                         | events;
         if (in_reset_vec) begin
            // Reset vector held until the core's first boundary
            if (accept_point) begin
               in_reset_vec <= 1'b0;
            end
         end else if (take_hw) begin
            // Eligible hardware source outranks a break at the same point
            irq_taken        <= 1'b1;
            set_disable_flag <= 1'b1;
            vector_low_addr  <= next_vec;
            vector_high_addr <= next_vec + `VIC_VEC_STEP;
         end else if (accept_point && software_break_instr) begin
            irq_taken        <= 1'b1;
            set_disable_flag <= 1'b1;
            vector_low_addr  <= `VIC_VEC_BRK;
            vector_high_addr <= `VIC_VEC_BRK + `VIC_VEC_STEP;
         end
      end
   end
endmodule // vectored_interrupt_control

// ### vic_defines.vh
// Purpose: constants for the vectored interrupt controller
// Assumes: 8-bit core with 16-bit vector addresses
// Notes: vector low bytes; high byte sits one above
// Summary of operation
// - Eight sources, fixed hardware priority, vectored
// - Each maskable source has request and enable
// - Accept when disable flag 0, request 1, enable 1
// - Reset is top priority, vector FFFD/FFFC
// - Key wakeup priority 2 on AND change
// - First pin priority 3, selected edge
// - Second pin priority 4, selected edge
// - Timer 2 underflow priority 5
// - Timer 3 underflow priority 6
// - Timer 1 underflow priority 7, stop release
// - Break instruction non-maskable, lowest, FFDD/FFDC
// - Disable flag is status bit 2
// - Request sets on event, clears on acceptance
// - Only highest pending accepted, rest wait
// - Acceptance clears request, sets disable flag
`ifndef VIC_DEFINES_VH
`define VIC_DEFINES_VH
`define VIC_NSRC        6
`define VIC_SRC_KEY     0
`define VIC_SRC_EXTA    1
`define VIC_SRC_EXTB    2
`define VIC_SRC_T2      3
`define VIC_SRC_T3      4
`define VIC_SRC_T1      5
`define VIC_IFLAG_BIT   2
`define VIC_VEC_RESET   16'hFFFC
`define VIC_VEC_KEY     16'hFFFA
`define VIC_VEC_EXTA    16'hFFF8
`define VIC_VEC_EXTB    16'hFFF6
`define VIC_VEC_T2      16'hFFF4
`define VIC_VEC_T3      16'hFFF2
`define VIC_VEC_T1      16'hFFF0
`define VIC_VEC_BRK     16'hFFDC
`define VIC_ZERO6       6'h00
`define VIC_ZERO16      16'h0000
`define VIC_ZERO8       8'h00
`define VIC_ZERO3       3'h0
`define VIC_VEC_STEP    16'h0001
`define VIC_GNT_KEY     6'h01
`define VIC_GNT_EXTA    6'h02
`define VIC_GNT_EXTB    6'h04
`define VIC_GNT_T2      6'h08
`define VIC_GNT_T3      6'h10
`define VIC_GNT_T1      6'h20
`define VIC_PRIME_CYCLES 3'h5
`define VIC_PRIME_ONE   3'h1
`endif

// ### vic_sync.v
// Purpose: three-stage synchroniser with agreement filter
// Assumes: asynchronous pin input
// Notes: first stage feeds only the second
`timescale 1ns/1ps
module vic_sync #(
   parameter W = 1
) (
   input  wire         clk,
   input  wire         rst_n,
   input  wire         ce,
   input  wire [W-1:0] din,
   output reg  [W-1:0] dout
);
   reg [W-1:0] s1;
   reg [W-1:0] s2;
   reg [W-1:0] s3;
   genvar i;
   generate
      for (i = 0; i < W; i = i + 1) begin : g_bit
         always @(posedge clk) begin
            if (!rst_n) begin
               s1[i]   <= 1'b0;
               s2[i]   <= 1'b0;
               s3[i]   <= 1'b0;
               dout[i] <= 1'b0;
            end else if (ce) begin
               s1[i] <= din[i];
               s2[i] <= s1[i];
               s3[i] <= s2[i];
               // Change counts only once stages two and three agree
               if (s2[i] == s3[i]) begin
                  dout[i] <= s3[i];
               end
            end
         end
      end
   endgenerate
endmodule // vic_sync

// ### vic_prio.v
// Purpose: fixed-priority selector for maskable sources
// Assumes: bit 0 is highest priority
// Notes: purely combinational
`timescale 1ns/1ps
`include "vic_defines.vh"
module vic_prio #(
   parameter N = `VIC_NSRC
) (
   input  wire [N-1:0] req,
   output reg  [N-1:0] grant,
   output reg          any
);
   integer k;
   reg     found;
   always @* begin
      found = 1'b0;
      grant = {N{1'b0}};
      for (k = 0; k < N; k = k + 1) begin
         if (req[k] && !found) begin
            grant[k] = 1'b1;
            found    = 1'b1;
         end
      end
      any = found;
   end
endmodule // vic_prio

// ### vic_assertions.sv
// Purpose: port-level checks of the interrupt controller
// Assumes: clock enable visible at the ports
// Notes: first accept point after reset is consumed
`timescale 1ns/1ps
module vic_assertions (
   input wire        clk,
   input wire        rst_n,
   input wire        ce,
   input wire        accept_point,
   input wire        software_break_instr,
   input wire        timer1_underflow,
   input wire        timer2_underflow,
   input wire        timer3_underflow,
   input wire [7:0]  status_in,
   input wire [5:0]  enable_bits,
   input wire [5:0]  request_bits,
   input wire        irq_taken,
   input wire [15:0] vector_low_addr,
   input wire [15:0] vector_high_addr,
   input wire        set_disable_flag,
   input wire        stop_release
);
   reg armed;
   // Consumed accept point would look like a missed acceptance
   always @(posedge clk)
      if (!rst_n) armed <= 1'b0;
      else if (accept_point && ce) armed <= 1'b1;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence s_ok;
      ce && accept_point && armed && !status_in[2] && |(request_bits & enable_bits);
   endsequence
   a_vec_pair: assert property (vector_high_addr == vector_low_addr + 16'h0001) else $error("pair");
   a_reset_vec: assert property (disable iff (1'b0) !rst_n |=> vector_low_addr == 16'hFFFC
      && request_bits == 6'h00) else $error("reset vector");
   a_take_flag: assert property (s_ok |=> irq_taken && set_disable_flag) else $error("take");
   a_key_first: assert property (s_ok ##0 (request_bits[0] && enable_bits[0])
      |=> vector_low_addr == 16'hFFFA) else $error("key prio");
   a_iflag_block: assert property (ce && accept_point && status_in[2] && !software_break_instr
      |=> !irq_taken) else $error("iflag");
   a_no_point: assert property (ce && !accept_point |=> !irq_taken) else $error("spurious");
   a_t2_set: assert property (ce && timer2_underflow |=> request_bits[3]) else $error("t2");
   a_t3_set: assert property (ce && timer3_underflow |=> request_bits[4]) else $error("t3");
   a_t1_stop: assert property (ce && timer1_underflow |=> stop_release && request_bits[5]) else $error("t1");
   a_brk_vec: assert property (ce && accept_point && armed && software_break_instr &&
      (status_in[2] || !(|(request_bits & enable_bits))) |=> vector_low_addr == 16'hFFDC) else $error("brk");
endmodule // vic_assertions
bind vectored_interrupt_control vic_assertions chk (.*);

// ### core_model.sv
// Purpose: processor core side, owns the disable flag
// Assumes: flag cleared only on request of the bench
// Notes: drives on the falling edge like the bench
`timescale 1ns/1ps
module core_model (
   input wire       clk,
   input wire       rst_n,
   input wire       set_disable_flag,
   input wire       cli,
   output reg [7:0] status_in
);
   initial status_in = 8'h04;
   always @(negedge clk)
      if (!rst_n) status_in <= 8'h04;
      else if (set_disable_flag) status_in[2] <= 1'b1;
      else if (cli) status_in[2] <= 1'b0;
endmodule // core_model

// ### vectored_interrupt_control_tb.sv
// Purpose: self-checking bench for the interrupt controller
// Assumes: core model holds the flag
// Notes: inputs change on the falling edge
`timescale 1ns/1ps
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin bad_count++; \
   $display("wrong value %s expected %h seen %h", n, e, a); end end
module vectored_interrupt_control_tb;
   reg clk = 0, rst_n = 0, accept_point = 0, software_break_instr = 0, cli = 0, ext_irq_a = 0, ext_irq_b = 1;
   reg ext_a_rising = 1, ext_b_rising = 0, timer1_underflow = 0, timer2_underflow = 0, timer3_underflow = 0, ce = 1;
   reg [7:0] key_port = 8'hFF, key_select = 8'h0F, key_port_dir = 8'h00;
   reg [5:0] enable_bits = 6'h3F, req_clear = 6'h00;
   wire [7:0] status_in;
   wire [5:0] request_bits;
   wire [15:0] vector_low_addr, vector_high_addr;
   wire irq_taken, set_disable_flag, stop_release;
   integer bad_count = 0, checks_done = 0, i;
   vectored_interrupt_control DUT (.*);
   core_model core (.*);
   initial forever #25 clk = ~clk;
   task close_out;
      $display("checks %0d errors %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // One accept point; c lets the core clear the flag afterwards
   task acc(input t, input [15:0] lo, input c);
      accept_point <= 1'b1;
      @(negedge clk) accept_point <= 1'b0;
      `CHK("taken", t, irq_taken)
      if (t) `CHK("vector", {lo + 16'h0001, lo}, {vector_high_addr, vector_low_addr})
      cli <= c;
      @(negedge clk) cli <= 1'b0;
      @(negedge clk);
   endtask
   initial begin
      repeat (3000) @(posedge clk);
      bad_count++;
      close_out;
   end
   initial begin
      repeat (16) @(negedge clk);
      `CHK("reset", {16'hFFFD, 16'hFFFC, 6'h00}, {vector_high_addr, vector_low_addr, request_bits})
      rst_n <= 1;
      @(negedge clk) acc(0, 16'h0000, 0);
      {timer1_underflow, timer2_underflow, timer3_underflow} <= 3'h7;
      @(negedge clk) {timer1_underflow, timer2_underflow, timer3_underflow} <= 3'h0;
      `CHK("request", 7'h78, {stop_release, request_bits})
      acc(0, 16'h0000, 1);
      `CHK("request", 6'h38, request_bits)
      acc(1, 16'hFFF4, 0);
      acc(0, 16'h0000, 1);
      acc(1, 16'hFFF2, 1);
      acc(1, 16'hFFF0, 1);
      enable_bits <= 6'h37;
      timer2_underflow <= 1;
      @(negedge clk) timer2_underflow <= 0;
      acc(0, 16'h0000, 0);
      `CHK("request", 6'h08, request_bits)
      req_clear <= 6'h08;
      @(negedge clk) req_clear <= 0;
      `CHK("request", 6'h00, request_bits)
      enable_bits <= 6'h3F;
      software_break_instr <= 1;
      acc(1, 16'hFFDC, 1);
      software_break_instr <= 0;
      // Frozen clock enable must swallow timer pulses
      {ce, timer1_underflow, timer3_underflow} <= 3'b011;
      @(negedge clk) {ce, timer1_underflow, timer3_underflow} <= 3'b100;
      `CHK("frozen", 7'h00, {stop_release, request_bits})
      {ext_irq_a, ext_irq_b, key_port} <= {2'b10, 8'hFE};
      repeat (8) @(negedge clk);
      `CHK("request", 6'h07, request_bits)
      for (i = 0; i < 3; i++) acc(1, 16'hFFFA - {i[14:0], 1'b0}, 1);
      // Opposite edges, and an output pin dropped from the key AND
      {ext_a_rising, ext_b_rising, key_port_dir} <= {2'b01, 8'h01};
      {ext_irq_a, ext_irq_b} <= 2'b01;
      repeat (8) @(negedge clk);
      `CHK("request", 6'h07, request_bits)
      close_out;
   end
endmodule // vectored_interrupt_control_tb
